// >>> hw/flash_host_pkg.sv
// What this block does
// - Erase resume only from read array mode
// - Resume continues programming; host must resume
// - Program is four writes, last latches
// - Failure holds status until F0 reset
// - Never write FF except as program data; follow with F0
// - Read/Reset: single F0 or three-cycle form
// - Auto select: AA, 55, 90 at bank
// - Chip erase six writes; block erase repeatable
// - Suspend B0, resume 30, CFI 98
// - Unlock bypass drops two unlock writes
package flash_host_pkg;

  // ************************************************************
  // Widths and bus addresses
  // ************************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam logic [11:0] UNLOCK_A_LOW = 12'haaa;
  localparam logic [ADDR_W-1:0] UNLOCK_A = 24'h000aaa;
  localparam logic [ADDR_W-1:0] UNLOCK_B = 24'h000555;

  // ************************************************************
  // Command codes written on the data pins
  // ************************************************************
  localparam logic [DATA_W-1:0] CODE_UNLOCK_A = 8'haa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_B = 8'h55;
  localparam logic [DATA_W-1:0] CODE_PROGRAM  = 8'ha0;
  localparam logic [DATA_W-1:0] CODE_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] CODE_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] CODE_BLOCK    = 8'h30;
  localparam logic [DATA_W-1:0] CODE_RESUME   = 8'h30;
  localparam logic [DATA_W-1:0] CODE_SUSPEND  = 8'hb0;
  localparam logic [DATA_W-1:0] CODE_AUTOSEL  = 8'h90;
  localparam logic [DATA_W-1:0] CODE_CFI      = 8'h98;
  localparam logic [DATA_W-1:0] CODE_RESET    = 8'hf0;

  // ************************************************************
  // Status bit positions
  // ************************************************************
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT  = 5;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SETUP_NS    = 10;
  localparam int T_PULSE_NS    = 35;
  localparam int T_ACCESS_NS   = 80;
  localparam int T_HOLD_NS     = 30;
  localparam int T_RST_LOW_NS  = 500;
  localparam int T_RST_REC_NS  = 50;
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC  = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_REC_CYC = (T_RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_LIMIT_DEFAULT = 1000000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_READ, CMD_RESET, CMD_RESET3, CMD_AUTOSEL, CMD_PROGRAM, CMD_CHIP_ERASE,
    CMD_BLOCK_ERASE, CMD_BLOCK_ADD, CMD_SUSPEND, CMD_RESUME, CMD_CFI, CMD_PIN_RESET
  } cmd_t;

  typedef struct packed {
    cmd_t              cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              bypass;
    logic              more;
  } hostReq_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              fail;
  } hostRsp_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } busCycle_t;

endpackage

// >>> hw/flash_bus_cycle.sv
`timescale 1ns/1ns
module flash_bus_cycle (
  input  wire logic                                ref_clk,
  input  wire logic                                rst_b,
  input  wire logic                                req,
  input  wire flash_host_pkg::busCycle_t           cyc,
  output logic                                     done,
  output logic [flash_host_pkg::DATA_W-1:0]        rdata,
  output logic [flash_host_pkg::ADDR_W-1:0]        flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0]        dqOut,
  output logic                                     dqOeB,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   dqIn,
  output logic                                     ceB,
  output logic                                     oeB,
  output logic                                     weB
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} phase_t;

  phase_t                            phase, next_phase;
  logic [7:0]                        cnt, next_cnt;
  logic                              isWrite, next_isWrite;
  logic                              next_done;
  logic [flash_host_pkg::DATA_W-1:0] next_rdata, next_dqOut;
  logic [flash_host_pkg::ADDR_W-1:0] next_flashAddr;
  logic                              next_dqOeB, next_ceB, next_oeB, next_weB;

  // ************************************************************
  // One asynchronous bus cycle: setup, strobe, hold
  // ************************************************************
  always_comb begin
    next_phase     = phase;
    next_cnt       = cnt + 8'h01;
    next_isWrite   = isWrite;
    next_done      = 1'b0;
    next_rdata     = rdata;
    next_flashAddr = flashAddr;
    next_dqOut     = dqOut;
    next_dqOeB     = dqOeB;
    next_ceB       = ceB;
    next_oeB       = oeB;
    next_weB       = weB;
    unique case (phase)
      E_IDLE: begin
        next_cnt = 8'h00;
        if (req) begin
          next_phase     = E_SETUP;
          next_isWrite   = cyc.write;
          next_flashAddr = cyc.addr;
          next_dqOut     = cyc.data;
          next_dqOeB     = !cyc.write; // Drive data only on writes
          next_ceB       = 1'b0;
        end
      end
      E_SETUP: begin
        if (cnt == 8'(flash_host_pkg::SETUP_CYC - 1)) begin
          next_phase = E_STROBE;
          next_cnt   = 8'h00;
          next_weB   = !isWrite;
          next_oeB   = isWrite;
        end
      end
      E_STROBE: begin
        if (isWrite ? (cnt == 8'(flash_host_pkg::PULSE_CYC - 1))
                    : (cnt == 8'(flash_host_pkg::ACCESS_CYC - 1))) begin
          next_phase = E_HOLD;
          next_cnt   = 8'h00;
          next_weB   = 1'b1; // Rising edge latches the write
          next_oeB   = 1'b1;
          if (!isWrite) begin
            next_rdata = dqIn;
          end
        end
      end
      E_HOLD: begin
        if (cnt == 8'(flash_host_pkg::HOLD_CYC - 1)) begin
          next_phase = E_IDLE;
          next_ceB   = 1'b1;
          next_dqOeB = 1'b1;
          next_done  = 1'b1;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase     <= E_IDLE;
      cnt       <= 8'h00;
      isWrite   <= 1'b0;
      done      <= 1'b0;
      rdata     <= '0;
      flashAddr <= '0;
      dqOut     <= '0;
      dqOeB     <= 1'b1;
      ceB       <= 1'b1;
      oeB       <= 1'b1;
      weB       <= 1'b1;
    end else begin
      phase     <= next_phase;
      cnt       <= next_cnt;
      isWrite   <= next_isWrite;
      done      <= next_done;
      rdata     <= next_rdata;
      flashAddr <= next_flashAddr;
      dqOut     <= next_dqOut;
      dqOeB     <= next_dqOeB;
      ceB       <= next_ceB;
      oeB       <= next_oeB;
      weB       <= next_weB;
    end
  end

endmodule

// >>> hw/flash_cmd_host.sv
`timescale 1ns/1ns
module flash_cmd_host #(
  parameter int POLL_LIMIT = flash_host_pkg::POLL_LIMIT_DEFAULT
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst_b,
  input  wire logic                                cmdValid,
  input  wire flash_host_pkg::hostReq_t            cmdReq,
  output logic                                     cmdReady,
  output logic                                     rspValid,
  output flash_host_pkg::hostRsp_t                 rsp,
  output logic                                     suspended,
  output logic [flash_host_pkg::ADDR_W-1:0]        flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0]        dqOut,
  output logic                                     dqOeB,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   dqIn,
  output logic                                     ceB,
  output logic                                     oeB,
  output logic                                     weB,
  output logic                                     rpB
);

  // Elaboration check on the poll ceiling
  if (POLL_LIMIT < 2) begin : g_bad_limit
    $error("POLL_LIMIT must be at least 2");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_WR, ST_RD, ST_POLL_A, ST_POLL_B, ST_VERIFY, ST_FIX,
    ST_PIN_LOW, ST_PIN_REC, ST_ANSWER
  } state_t;

  // ************************************************************
  // Command sequence tables
  // ************************************************************
  // Bank address with the low unlock offset
  function automatic logic [flash_host_pkg::ADDR_W-1:0] bankAaa(
    input logic [flash_host_pkg::ADDR_W-1:0] a);
    bankAaa = {a[flash_host_pkg::ADDR_W-1:12], flash_host_pkg::UNLOCK_A_LOW};
  endfunction

  // Number of write cycles of a command
  function automatic logic [2:0] seqLen(input flash_host_pkg::hostReq_t r);
    unique case (r.cmd)
      flash_host_pkg::CMD_RESET3, flash_host_pkg::CMD_AUTOSEL: seqLen = 3'd3;
      flash_host_pkg::CMD_PROGRAM:      seqLen = r.bypass ? 3'd2 : 3'd4;
      flash_host_pkg::CMD_CHIP_ERASE,
      flash_host_pkg::CMD_BLOCK_ERASE:  seqLen = 3'd6;
      default:                          seqLen = 3'd1;
    endcase
  endfunction

  // Address and data of write cycle idx; FF only when the program data of the request is FF
  function automatic flash_host_pkg::busCycle_t seqStep(
    input flash_host_pkg::hostReq_t r, input logic [2:0] idx);
    logic [2:0] eff;
    eff = (r.cmd == flash_host_pkg::CMD_PROGRAM && r.bypass) ? idx + 3'd2 : idx;
    seqStep = '{write: 1'b1, addr: r.addr, data: flash_host_pkg::CODE_RESET};
    unique case (r.cmd)
      flash_host_pkg::CMD_SUSPEND: seqStep.data = flash_host_pkg::CODE_SUSPEND;
      flash_host_pkg::CMD_RESUME:  seqStep.data = flash_host_pkg::CODE_RESUME;
      flash_host_pkg::CMD_BLOCK_ADD: seqStep.data = flash_host_pkg::CODE_BLOCK;
      flash_host_pkg::CMD_CFI: begin
        seqStep.addr = bankAaa(r.addr);
        seqStep.data = flash_host_pkg::CODE_CFI;
      end
      flash_host_pkg::CMD_RESET: ;
      default: begin
        unique case (eff)
          3'd0, 3'd3: begin
            // Fourth program write carries the target data, not an unlock
            if (eff == 3'd3 && r.cmd == flash_host_pkg::CMD_PROGRAM) begin
              seqStep.data = r.data;
            end else begin
              seqStep.addr = flash_host_pkg::UNLOCK_A;
              seqStep.data = flash_host_pkg::CODE_UNLOCK_A;
            end
          end
          3'd1, 3'd4: begin
            seqStep.addr = flash_host_pkg::UNLOCK_B;
            seqStep.data = flash_host_pkg::CODE_UNLOCK_B;
          end
          3'd2: begin
            seqStep.addr = flash_host_pkg::UNLOCK_A;
            if (r.cmd == flash_host_pkg::CMD_PROGRAM) begin
              seqStep.data = flash_host_pkg::CODE_PROGRAM;
            end else if (r.cmd == flash_host_pkg::CMD_AUTOSEL) begin
              seqStep.addr = bankAaa(r.addr);
              seqStep.data = flash_host_pkg::CODE_AUTOSEL;
            end else if (r.cmd == flash_host_pkg::CMD_RESET3) begin
              seqStep.addr = r.addr;
            end else begin
              seqStep.data = flash_host_pkg::CODE_ERASE;
            end
          end
          default: begin
            if (r.cmd == flash_host_pkg::CMD_PROGRAM) begin
              seqStep.data = r.data;
            end else if (r.cmd == flash_host_pkg::CMD_CHIP_ERASE) begin
              seqStep.addr = flash_host_pkg::UNLOCK_A;
              seqStep.data = flash_host_pkg::CODE_CHIP;
            end else begin
              seqStep.data = flash_host_pkg::CODE_BLOCK;
            end
          end
        endcase
      end
    endcase
  endfunction

  // Commands that start an operation the host must poll
  function automatic logic needsPoll(input flash_host_pkg::hostReq_t r);
    unique case (r.cmd)
      flash_host_pkg::CMD_PROGRAM, flash_host_pkg::CMD_CHIP_ERASE,
      flash_host_pkg::CMD_SUSPEND, flash_host_pkg::CMD_RESUME: needsPoll = 1'b1;
      flash_host_pkg::CMD_BLOCK_ERASE, flash_host_pkg::CMD_BLOCK_ADD: needsPoll = !r.more;
      default: needsPoll = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Sequencer state
  // ************************************************************
  state_t                            state, next_state;
  flash_host_pkg::hostReq_t          req, next_req;
  logic [2:0]                        idx, next_idx;
  logic [31:0]                       cnt, next_cnt;
  logic [flash_host_pkg::DATA_W-1:0] first, next_first;
  logic                              autoSel, next_autoSel;
  logic                              cfiMode, next_cfiMode;
  logic                              busReq, next_busReq;
  flash_host_pkg::busCycle_t         busCyc, next_busCyc;
  logic                              next_cmdReady, next_rspValid, next_suspended, next_rpB;
  flash_host_pkg::hostRsp_t          next_rsp;
  logic                              busDone;
  logic [flash_host_pkg::DATA_W-1:0] busData;
  logic                              toggled;

  assign toggled = first[flash_host_pkg::TOGGLE_BIT] != busData[flash_host_pkg::TOGGLE_BIT];

  // Next state of the command sequencer
  always_comb begin
    next_state     = state;
    next_req       = req;
    next_idx       = idx;
    next_cnt       = cnt;
    next_first     = first;
    next_autoSel   = autoSel;
    next_cfiMode   = cfiMode;
    next_busReq    = 1'b0;
    next_busCyc    = busCyc;
    next_cmdReady  = 1'b0;
    next_rspValid  = 1'b0;
    next_rsp       = rsp;
    next_suspended = suspended;
    next_rpB       = rpB;
    unique case (state)
      ST_IDLE: begin
        next_cmdReady = 1'b1;
        if (cmdValid && cmdReady) begin
          next_cmdReady = 1'b0;
          next_req      = cmdReq;
          next_idx      = 3'd0;
          next_cnt      = '0;
          next_rsp      = '{data: '0, fail: 1'b0};
          next_busReq   = 1'b1;
          if (cmdReq.cmd == flash_host_pkg::CMD_PIN_RESET) begin
            next_busReq = 1'b0;
            next_rpB    = 1'b0;
            next_state  = ST_PIN_LOW;
          end else if (cmdReq.cmd == flash_host_pkg::CMD_READ) begin
            next_busCyc = '{write: 1'b0, addr: cmdReq.addr, data: '0};
            next_state  = ST_RD;
          end else if (cmdReq.cmd == flash_host_pkg::CMD_RESUME && (autoSel || cfiMode)) begin
            next_busCyc = '{write: 1'b1, addr: cmdReq.addr,
                            data: flash_host_pkg::CODE_RESET};
            next_state  = ST_PRE;
          end else begin
            next_busCyc = seqStep(cmdReq, 3'd0);
            next_state  = ST_WR;
          end
        end
      end
      ST_PRE: begin
        if (busDone) begin
          // Leave CFI first, then auto select, then resume
          if (cfiMode) begin
            next_cfiMode = 1'b0;
          end else begin
            next_autoSel = 1'b0;
          end
          next_busReq = 1'b1;
          if (cfiMode && autoSel) begin
            next_busCyc = '{write: 1'b1, addr: req.addr, data: flash_host_pkg::CODE_RESET};
          end else begin
            next_busCyc = seqStep(req, 3'd0);
            next_state  = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (busDone) begin
          if (idx != seqLen(req) - 3'd1) begin
            next_idx    = idx + 3'd1;
            next_busReq = 1'b1;
            next_busCyc = seqStep(req, idx + 3'd1);
          end else begin
            // Track the read mode the device now sits in
            unique case (req.cmd)
              flash_host_pkg::CMD_AUTOSEL: next_autoSel = 1'b1;
              flash_host_pkg::CMD_CFI:     next_cfiMode = 1'b1;
              flash_host_pkg::CMD_RESET, flash_host_pkg::CMD_RESET3: begin
                if (cfiMode) begin
                  next_cfiMode = 1'b0;
                end else begin
                  next_autoSel = 1'b0;
                end
              end
              default: ;
            endcase
            if (needsPoll(req)) begin
              next_busReq = 1'b1;
              next_busCyc = '{write: 1'b0, addr: req.addr, data: '0};
              next_state  = ST_POLL_A;
            end else begin
              next_state = ST_ANSWER;
            end
          end
        end
      end
      ST_RD: begin
        if (busDone) begin
          next_rsp.data = busData;
          next_state    = ST_ANSWER;
        end
      end
      ST_POLL_A: begin
        if (busDone) begin
          next_first  = busData;
          next_busReq = 1'b1;
          next_state  = ST_POLL_B;
        end
      end
      ST_POLL_B: begin
        if (busDone) begin
          next_cnt = cnt + 32'd1;
          if (!toggled) begin
            // Toggle stopped: done, suspended, or ignored on a protected block
            next_suspended = req.cmd == flash_host_pkg::CMD_SUSPEND;
            next_rsp.data  = busData;
            if (req.cmd == flash_host_pkg::CMD_PROGRAM) begin
              next_busReq = 1'b1;
              next_state  = ST_VERIFY;
            end else begin
              next_state = ST_ANSWER;
            end
          end else if ((first[flash_host_pkg::ERROR_BIT] && busData[flash_host_pkg::ERROR_BIT])
                       || cnt == 32'(POLL_LIMIT - 1)) begin
            next_rsp.fail = 1'b1;
            next_busReq   = 1'b1;
            next_busCyc   = '{write: 1'b1, addr: req.addr,
                              data: flash_host_pkg::CODE_RESET};
            next_state    = ST_FIX;
          end else begin
            next_busReq = 1'b1;
            next_state  = ST_POLL_A;
          end
        end
      end
      ST_VERIFY: begin
        if (busDone) begin
          next_rsp.data = busData;
          // A one that the target asked for cannot be set by programming
          next_rsp.fail = busData != req.data;
          next_state    = ST_ANSWER;
        end
      end
      ST_FIX: begin
        if (busDone) begin
          next_state = ST_ANSWER;
        end
      end
      ST_PIN_LOW: begin
        next_cnt = cnt + 32'd1;
        if (cnt == 32'(flash_host_pkg::RST_LOW_CYC - 1)) begin
          next_rpB       = 1'b1;
          next_cnt       = '0;
          next_autoSel   = 1'b0;
          next_cfiMode   = 1'b0;
          next_suspended = 1'b0;
          next_state     = ST_PIN_REC;
        end
      end
      ST_PIN_REC: begin
        next_cnt = cnt + 32'd1;
        if (cnt == 32'(flash_host_pkg::RST_REC_CYC - 1)) begin
          next_state = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_rspValid = 1'b1;
        next_state    = ST_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      req       <= '0;
      idx       <= 3'd0;
      cnt       <= '0;
      first     <= '0;
      autoSel   <= 1'b0;
      cfiMode   <= 1'b0;
      busReq    <= 1'b0;
      busCyc    <= '0;
      cmdReady  <= 1'b0;
      rspValid  <= 1'b0;
      rsp       <= '0;
      suspended <= 1'b0;
      rpB       <= 1'b1;
    end else begin
      state     <= next_state;
      req       <= next_req;
      idx       <= next_idx;
      cnt       <= next_cnt;
      first     <= next_first;
      autoSel   <= next_autoSel;
      cfiMode   <= next_cfiMode;
      busReq    <= next_busReq;
      busCyc    <= next_busCyc;
      cmdReady  <= next_cmdReady;
      rspValid  <= next_rspValid;
      rsp       <= next_rsp;
      suspended <= next_suspended;
      rpB       <= next_rpB;
    end
  end

  // ************************************************************
  // Pin-level bus cycle engine
  // ************************************************************
  flash_bus_cycle u_bus (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .req       (busReq),
    .cyc       (busCyc),
    .done      (busDone),
    .rdata     (busData),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqOeB     (dqOeB),
    .dqIn      (dqIn),
    .ceB       (ceB),
    .oeB       (oeB),
    .weB       (weB)
  );

endmodule

// >>> verification/flash_cmd_host_sva.sv
`timescale 1ns/1ns
// Timing and code checks on the flash pins
module flash_cmd_host_sva (
  input wire logic                     ref_clk,
  input wire logic                     rst_b,
  input wire logic                     cmdValid,
  input wire flash_host_pkg::hostReq_t cmdReq,
  input wire logic                     cmdReady,
  input wire logic [23:0]              flashAddr,
  input wire logic [7:0]               dqOut,
  input wire logic                     dqOeB,
  input wire logic                     ceB,
  input wire logic                     oeB,
  input wire logic                     weB,
  input wire logic                     rpB
);
  logic take;
  // Command taken at this edge
  assign take = cmdValid && cmdReady;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_no_ff_code: assert property (!weB |-> dqOut != 8'hff)
    else $error("ff written");
  a_write_drive: assert property (!weB |-> !ceB && oeB && !dqOeB)
    else $error("write strobe bad");
  a_we_width: assert property ($fell(weB) |=> !weB [*8] ##1 weB)
    else $error("write width");
  a_reset_code: assert property (take && cmdReq.cmd == flash_host_pkg::CMD_RESET |->
    ##[2:12] $fell(weB) && dqOut == 8'hf0) else $error("reset code");
  a_resume_code: assert property (take && cmdReq.cmd == flash_host_pkg::CMD_RESUME |->
    ##[2:12] $fell(weB) && dqOut inside {8'h30, 8'hf0}) else $error("resume code");
  a_suspend_code: assert property (take && cmdReq.cmd == flash_host_pkg::CMD_SUSPEND |->
    ##[2:12] $fell(weB) && dqOut == 8'hb0) else $error("suspend code");
  a_autosel_unlock: assert property (take && cmdReq.cmd == flash_host_pkg::CMD_AUTOSEL |->
    ##[2:12] $fell(weB) && dqOut == 8'haa && flashAddr == 24'haaa) else $error("unlock");
  a_bypass_prog: assert property (take && cmdReq.cmd == flash_host_pkg::CMD_PROGRAM &&
    cmdReq.bypass |-> ##[2:12] $fell(weB) && dqOut == 8'ha0) else $error("bypass");
  a_pin_reset: assert property ($fell(rpB) |-> ##[120:130] $rose(rpB))
    else $error("pin reset width");
endmodule
bind flash_cmd_host flash_cmd_host_sva u_sva (.ref_clk, .rst_b, .cmdValid, .cmdReq,
  .cmdReady, .flashAddr, .dqOut, .dqOeB, .ceB, .oeB, .weB, .rpB);

// >>> verification/flash_dev_model.sv
`timescale 1ns/1ns
// Byte-mode flash array with a small command decoder
module flash_dev_model (
  input  wire logic        ceB,
  input  wire logic        oeB,
  input  wire logic        weB,
  input  wire logic        rpB,
  input  wire logic [23:0] flashAddr,
  input  wire logic [7:0]  dqOut,
  output logic [7:0]       dqIn
);
  logic [7:0] mem [16] = '{default: 8'hff};
  logic [1:0] step = 2'h0;
  logic [1:0] busy = 2'h0;
  logic       tog  = 1'b0;
  logic       held = 1'b0;
  logic [7:0] rd;
  // Status at any address while busy and not suspended, array otherwise; released bus shows inverse
  assign rd   = (busy != 2'h0 && !held) ? {1'b0, tog, 6'h0} : mem[flashAddr[3:0]];
  assign dqIn = (!ceB && !oeB) ? rd : ~rd;
  // Write decode, read side effects, pin reset abort
  always @(posedge weB or negedge oeB or negedge rpB) begin
    if (!rpB) begin
      step <= 2'h0;
      busy <= 2'h0;
      held <= 1'b0;
    end else if (!oeB) begin
      if (busy != 2'h0 && !held) begin
        tog  <= !tog;
        busy <= busy - 2'h1;
      end
    end else if (step == 2'h3) begin
      if (!flashAddr[23]) mem[flashAddr[3:0]] <= mem[flashAddr[3:0]] & dqOut;
      busy <= flashAddr[23] ? 2'h0 : 2'h3;
      step <= 2'h0;
    end else if (dqOut == 8'hb0) held <= busy != 2'h0;
    else if (dqOut == 8'h30) held <= 1'b0;
    else if (dqOut == 8'haa) step <= 2'h1;
    else if (dqOut == 8'h55 && step == 2'h1) step <= 2'h2;
    else if (dqOut == 8'ha0) step <= 2'h3;
    else step <= 2'h0;
  end
endmodule

// >>> verification/flash_cmd_host_test.sv
`timescale 1ns/1ns
module flash_cmd_host_test;
  typedef struct packed {
    flash_host_pkg::cmd_t c;
    logic [23:0]          a;
    logic [7:0]           d;
    logic                 by;
    logic [7:0]           q;
    logic                 f;
    logic                 s;
    logic [2:0]           k;
  } row_t;
  logic                     ref_clk, rst_b, cmdValid, cmdReady, rspValid, suspended;
  logic                     dqOeB, ceB, oeB, weB, rpB;
  flash_host_pkg::hostReq_t cmdReq;
  flash_host_pkg::hostRsp_t rsp;
  logic [23:0]              flashAddr;
  logic [7:0]               dqOut, dqIn;
  int                       n_mismatch, comparisons, cycles;
  row_t rows [14] = '{
    '{flash_host_pkg::CMD_READ, 24'h1, 8'h0, 1'b0, 8'hff, 1'b0, 1'b0, 3'h1},
    '{flash_host_pkg::CMD_PROGRAM, 24'h1, 8'h5a, 1'b0, 8'h0, 1'b0, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_PROGRAM, 24'h1, 8'hf0, 1'b1, 8'h0, 1'b1, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_READ, 24'h1, 8'h0, 1'b0, 8'h50, 1'b0, 1'b0, 3'h1},
    '{flash_host_pkg::CMD_PROGRAM, 24'h800001, 8'h0, 1'b0, 8'h0, 1'b1, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_SUSPEND, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b1, 3'h4},
    '{flash_host_pkg::CMD_AUTOSEL, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h0},
    '{flash_host_pkg::CMD_RESUME, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h6},
    '{flash_host_pkg::CMD_CHIP_ERASE, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_BLOCK_ERASE, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_BLOCK_ADD, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h2},
    '{flash_host_pkg::CMD_RESET3, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h0},
    '{flash_host_pkg::CMD_CFI, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h0},
    '{flash_host_pkg::CMD_RESET, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h0}
  };
  flash_cmd_host #(.POLL_LIMIT(16)) u_dut (.ref_clk, .rst_b, .cmdValid, .cmdReq, .cmdReady,
    .rspValid, .rsp, .suspended, .flashAddr, .dqOut, .dqOeB, .dqIn, .ceB, .oeB, .weB, .rpB);
  flash_dev_model u_dev (.ceB, .oeB, .weB, .rpB, .flashAddr, .dqOut, .dqIn);
  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input row_t r);
    int n;
    cmdReq   <= '{r.c, r.a, r.d, r.by, 1'b0};
    cmdValid <= 1'b1;
    do @(posedge ref_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 9000);
    if (r.k[0]) cmp(rsp.data, r.q);
    if (r.k[1]) cmp(8'(rsp.fail), 8'(r.f));
    if (r.k[2]) cmp(8'(suspended), 8'(r.s));
  endtask
  task automatic hold_reset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge ref_clk);
    cmp({5'h0, cmdReady, weB, rpB}, 8'h3);
    rst_b <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic complete_run();
    $display("%0d mismatches in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Table pass, then pin reset and mid-run reset
  initial begin
    cmdValid = 1'b0;
    cmdReq   = '0;
    hold_reset(16);
    foreach (rows[i]) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    run('{flash_host_pkg::CMD_PIN_RESET, 24'h0, 8'h0, 1'b0, 8'h0, 1'b0, 1'b0, 3'h0});
    run('{flash_host_pkg::CMD_READ, 24'h1, 8'h0, 1'b0, 8'h50, 1'b0, 1'b0, 3'h1});
    $display("pin reset test done");
    hold_reset(3);
    run('{flash_host_pkg::CMD_READ, 24'h1, 8'h0, 1'b0, 8'h50, 1'b0, 1'b0, 3'h1});
    $display("reset test done");
    complete_run();
  end
endmodule
